// *** rtl/upgb_bank.sv ***
// upper parallel io bank: direction, level and drive-enable registers with pin control
`timescale 1ns/1ps
module upgb_bank #(
    parameter int PINS = upgb_pkg::PIN_COUNT
) (
    input wire logic ref_clk, // 25 MHz clock
    input wire logic rst, // async reset, active high
    input wire logic [upgb_pkg::ADDR_W-1:0] regAddr, // register address
    input wire logic [upgb_pkg::REG_W-1:0] regWdata, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [upgb_pkg::REG_W-1:0] regRdata, // read data, cycle after strobe
    input wire logic [PINS-1:0] pinIn, // pin levels 32..45
    output logic [PINS-1:0] pinOut, // pin output values
    output logic [PINS-1:0] pinOe // pin output enables, high drives
);
    import upgb_pkg::*;

    // refuse sizes that the fixed register layout cannot serve
    if (PINS != PIN_COUNT) begin : g_badPins
        $error("upgb_bank: PINS must equal PIN_COUNT");
    end
    if (PINS + 2 != REG_W) begin : g_badWidth
        $error("upgb_bank: pin bits plus reserved bits must fill one register");
    end
    if (RSVD_LSB != PINS) begin : g_badRsvd
        $error("upgb_bank: reserved field must sit just above the pin bits");
    end
    if (ADDR_W < 16) begin : g_badAddr
        $error("upgb_bank: address bus too narrow for the register offsets");
    end
    if (DIR_OFS == LEVEL_OFS || DIR_OFS == DRIVE_EN_OFS || LEVEL_OFS == DRIVE_EN_OFS) begin : g_badMap
        $error("upgb_bank: register offsets must differ");
    end
    if (SYNC_STAGES != 2) begin : g_badSync
        $error("upgb_bank: synchroniser is built for two stages");
    end
    if (RESET_SAMPLE_CYCLES < SYNC_STAGES || RESET_SAMPLE_CYCLES > 3) begin : g_badInit
        $error("upgb_bank: reset sample count must cover the synchroniser and fit the counter");
    end
    if (DIR_RESET[REG_W-1:RSVD_LSB] != RSVD_RESET) begin : g_badDirRst
        $error("upgb_bank: direction reset must clear the reserved bits");
    end
    if (DRIVE_EN_RESET[REG_W-1:RSVD_LSB] != RSVD_RESET) begin : g_badEnRst
        $error("upgb_bank: drive enable reset must clear the reserved bits");
    end

    logic [PINS-1:0] dir_r;
    logic [PINS-1:0] driveEn_r;
    logic [PINS-1:0] outVal_r;
    logic [1:0] dirRsvd_r;
    logic [1:0] enRsvd_r;
    logic [1:0] lvlRsvd_r;
    logic [PINS-1:0] sync1_r;
    logic [PINS-1:0] sync2_r;
    logic [1:0] initCnt_r;
    logic initDone_r;
    logic [PINS-1:0] levelView;
    logic [REG_W-1:0] rdata_nxt;

    logic hitDir;
    logic hitEn;
    logic hitLvl;
    logic wrDir;
    logic wrEn;
    logic wrLvl;
    logic [REG_W-1:0] dirWord;
    logic [REG_W-1:0] enWord;
    logic [REG_W-1:0] lvlWord;

    // exact match only: other addresses are ignored on write and read as zero
    always_comb begin
        hitDir = (regAddr == DIR_OFS);
        hitEn = (regAddr == DRIVE_EN_OFS);
        hitLvl = (regAddr == LEVEL_OFS);
    end

    always_comb begin
        wrDir = regWr && hitDir;
        wrEn = regWr && hitEn;
        wrLvl = regWr && hitLvl;
    end

    // register images as software reads them
    always_comb begin
        dirWord = {dirRsvd_r, dir_r};
        enWord = {enRsvd_r, driveEn_r};
        lvlWord = {lvlRsvd_r, levelView};
    end

    // two-stage synchroniser; stage one feeds stage two only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
        end else begin
            sync1_r <= pinIn;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync2_r <= '0;
        end else begin
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dir_r <= DIR_RESET[PINS-1:0];
        end else if (wrDir) begin
            dir_r <= regWdata[PINS-1:0];
        end
    end

    // reserved bits only store what software wrote
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dirRsvd_r <= RSVD_RESET;
        end else if (wrDir) begin
            dirRsvd_r <= regWdata[RSVD_LSB+1:RSVD_LSB];
        end
    end

    // drive enable; a pin drives only where enable and direction are both set
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            driveEn_r <= DRIVE_EN_RESET[PINS-1:0];
        end else if (wrEn) begin
            driveEn_r <= regWdata[PINS-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            enRsvd_r <= RSVD_RESET;
        end else if (wrEn) begin
            enRsvd_r <= regWdata[RSVD_LSB+1:RSVD_LSB];
        end
    end

    // count off the synchroniser after reset so stored levels start as pin values
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            initCnt_r <= 2'h0;
        end else if (!initDone_r) begin
            initCnt_r <= initCnt_r + 2'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            initDone_r <= 1'b0;
        end else if (initCnt_r == 2'(RESET_SAMPLE_CYCLES)) begin
            initDone_r <= 1'b1;
        end
    end

    // output latch: written in output mode; tracks pin while input so a
    // switch to output starts from the current pin level
    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_pin
            logic loadWr;
            logic trackPin;

            always_comb begin
                loadWr = wrLvl && dir_r[i];
                trackPin = !initDone_r || !dir_r[i];
            end

            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    outVal_r[i] <= 1'b0;
                end else if (loadWr) begin
                    outVal_r[i] <= regWdata[i];
                end else if (trackPin) begin
                    outVal_r[i] <= sync2_r[i];
                end
            end
            assign levelView[i] = dir_r[i] ? outVal_r[i] : sync2_r[i];
            assign pinOut[i] = outVal_r[i];
            assign pinOe[i] = driveEn_r[i] && dir_r[i];
        end
    endgenerate

    // reserved bits of the level register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lvlRsvd_r <= RSVD_RESET;
        end else if (wrLvl) begin
            lvlRsvd_r <= regWdata[RSVD_LSB+1:RSVD_LSB];
        end
    end

    always_comb begin
        rdata_nxt = '0;
        if (regRd) begin
            case (regAddr)
                DIR_OFS: begin
                    rdata_nxt = dirWord;
                end
                DRIVE_EN_OFS: begin
                    rdata_nxt = enWord;
                end
                LEVEL_OFS: begin
                    rdata_nxt = lvlWord;
                end
                default: begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regRdata <= '0;
        end else begin
            regRdata <= rdata_nxt;
        end
    end
endmodule

// *** rtl/upgb_pkg.sv ***
// constants and register map of the upper parallel io pin bank
// Behaviour
// - direction bits 13..0, reset to zero
// - direction zero: level bit shows pin input
// - direction one: level bit holds driven value
// - input mode reads pin low/high as 0/1
// - output mode drives written level onto pin
// - level bits after reset take pin values
// - bits 0..13 map pins 32..45 ascending
// - enable zero: pin never driven
package upgb_pkg;
    localparam int REG_W = 16;
    localparam int ADDR_W = 16;
    localparam int PIN_COUNT = 14;
    localparam int FIRST_PIN = 32;
    localparam logic [15:0] DRIVE_EN_OFS = 16'h4406;
    localparam logic [15:0] DIR_OFS = 16'h4407;
    localparam logic [15:0] LEVEL_OFS = 16'h4408;
    localparam logic [15:0] DIR_RESET = 16'h0000;
    localparam logic [15:0] DRIVE_EN_RESET = 16'h0000;
    localparam logic [1:0] RSVD_RESET = 2'h0;
    localparam int RSVD_LSB = 14;
    localparam int SYNC_STAGES = 2;
    localparam int RESET_SAMPLE_CYCLES = 2;
endpackage

// *** testbench/upgb_bank_monitor.sv ***
// port checker for the upper io bank
`timescale 1ns/1ps
module upgb_bank_monitor import upgb_pkg::*; (
    input wire logic ref_clk, // clock
    input wire logic rst, // reset
    input wire logic [15:0] regAddr, // address
    input wire logic [15:0] regWdata, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    input wire logic [15:0] regRdata, // read data
    input wire logic [13:0] pinIn, // pin levels
    input wire logic [13:0] pinOut, // pin values
    input wire logic [13:0] pinOe // pin enables
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_idle_read_zero: assert property (!$past(regRd) |-> regRdata == 16'h0000)
        else $error("read data outside read slot");
    a_level_to_pin: assert property (regWr && regAddr == LEVEL_OFS |=>
        (pinOut & pinOe) == ($past(regWdata[13:0]) & pinOe)) else $error("pin level");
    a_oe_hold: assert property (!$past(regWr) |-> $stable(pinOe))
        else $error("enable moved");
    a_out_hold: assert property (!$past(regWr) |-> $stable(pinOut & pinOe))
        else $error("driven value moved");
    a_dir_read_oe: assert property ($past(regRd && regAddr == DIR_OFS) |->
        (regRdata[13:0] & pinOe) == pinOe) else $error("dir vs enable");
    a_level_read_drv: assert property ($past(regRd && regAddr == LEVEL_OFS) |->
        (regRdata[13:0] & pinOe) == (pinOut & pinOe)) else $error("level read");
    a_unmapped_zero: assert property ($past(regRd && regAddr > LEVEL_OFS) |->
        regRdata == 16'h0000) else $error("unmapped read");
    c_level_wr: cover property (regWr && regAddr == LEVEL_OFS);
    c_dir_rd: cover property (regRd && regAddr == DIR_OFS);
    c_drive: cover property (pinOe != 14'h0000);
endmodule
bind upgb_bank upgb_bank_monitor chk (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));

// *** testbench/upgb_pin_model.sv ***
// board side of the pins: driven level wins, else external level
`timescale 1ns/1ps
module upgb_pin_model (
    input wire logic [13:0] pinOut, // device values
    input wire logic [13:0] pinOe, // device enables
    input wire logic [13:0] extLevel, // board level
    output logic [13:0] pinIn // wire level
);
    assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// *** testbench/upper_parallel_gpio_bank_tb_top.sv ***
// self-checking bench for the upper io bank
`timescale 1ns/1ps
module upper_parallel_gpio_bank_tb_top;
    import upgb_pkg::*;
    logic ref_clk = 0, rst = 1, regWr = 0, regRd = 0, rdP = 0;
    logic [15:0] regAddr = 0, regWdata = 0, regRdata, d;
    logic [13:0] pinIn, pinOut, pinOe, ext = 0;
    logic [15:0] q[$];
    int n_fail = 0, total_checks = 0, seed = 32'h670e;
    always #20 ref_clk = ~ref_clk;
    upgb_bank uut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe));
    upgb_pin_model pm (.pinOut(pinOut), .pinOe(pinOe), .extLevel(ext), .pinIn(pinIn));
    task chk(input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("Error %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task acc(input logic w, input logic [15:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        regWr <= w;
        regRd <= !w;
        regAddr <= a;
        regWdata <= v;
        if (!w) q.push_back(v);
        @(posedge ref_clk);
        regWr <= 0;
        regRd <= 0;
    endtask
    always @(posedge ref_clk) begin
        if (rdP) chk(regRdata, q.pop_front());
        rdP <= regRd;
    end
    initial begin
        ext <= 14'($random(seed));
        repeat (12) @(posedge ref_clk);
        rst <= 0;
        repeat (4) @(posedge ref_clk);
        acc(0, LEVEL_OFS, {2'h0, ext});
        acc(0, DIR_OFS, 16'h0000);
        acc(1, DIR_OFS, 16'hFFFF);
        acc(1, DRIVE_EN_OFS, 16'h3FFF);
        acc(0, DRIVE_EN_OFS, 16'h3FFF);
        d = 16'($random(seed));
        acc(1, LEVEL_OFS, d);
        acc(0, DIR_OFS, 16'hFFFF);
        acc(0, LEVEL_OFS, d);
        chk({2'h0, pinOut & pinOe}, {2'h0, d[13:0]});
        acc(1, DIR_OFS, 16'h0000);
        acc(1, DRIVE_EN_OFS, 16'h0000);
        ext <= 14'($random(seed));
        chk({2'h0, pinOe}, 16'h0000);
        repeat (4) @(posedge ref_clk);
        acc(0, LEVEL_OFS, {d[15:14], ext});
        acc(1, DIR_OFS, 16'h3FFF);
        acc(1, DRIVE_EN_OFS, 16'h3FFF);
        chk({2'h0, pinOut}, {2'h0, ext});
        acc(0, 16'h4409, 16'h0000);
        repeat (3) @(posedge ref_clk);
        give_verdict;
    end
    initial begin
        #100us;
        n_fail++;
        give_verdict;
    end
endmodule
